// *** src/psc_pkg.sv ***
// Shared constants and types of the power saving clock control block.
// Assumes one 25 MHz clock and a classic Wishbone master with 32-bit data.
package psc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [7:0] ADDR_REGULATOR = 8'h00;
    localparam logic [7:0] ADDR_THROTTLE = 8'h04;
    localparam logic [7:0] ADDR_MODULE_OFF = 8'h08;
    localparam logic [7:0] ADDR_SYSCLK_GATE = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int REG_LOW_POWER_BIT = 1;
    localparam logic [7:0] REGULATOR_RST = 8'h01;
    localparam logic [7:0] REGULATOR_WMASK = 8'h02;
    localparam logic [7:0] REGULATOR_FIXED = 8'h01;
    localparam int IDLE_SEL_BIT = 7;
    localparam int THROTTLE_BIT = 6;
    localparam int WAKE_FULL_BIT = 5;
    localparam int THR_RETURN_BIT = 4;
    localparam int RATIO_W = 3;
    localparam logic [7:0] THROTTLE_RST = 8'h00;
    localparam logic [7:0] THROTTLE_WMASK = 8'hF7;
    localparam int GATE_BIT = 0;
    localparam logic [7:0] MODULE_OFF_RST = 8'h00;

    // ------------------------------------------------------------
    // Timing: instruction clock is the system clock divided by four
    // ------------------------------------------------------------
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
    localparam logic [8:0] RATIO_BASE = 9'h002;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSC_RUN = 2'b00,
        PSC_IDLE = 2'b01,
        PSC_SLEEP = 2'b11
    } psc_state_t;

    typedef struct packed {
        logic sleep_instr;
        logic isr_entry;
        logic return_from_isr_instr;
        logic in_circuit_debugger;
        logic irq_pending;
        logic wdt_timeout;
    } psc_cpu_ev_t;

    typedef struct packed {
        logic sys_clk_en;
        logic instr_clk_en;
        logic cpu_clk_en;
        logic periph_sysclk_en;
        logic sleep_regulator_low_power;
        logic wdt_reset;
    } psc_clk_out_t;

endpackage

// *** src/psc_power_ctrl.sv ***
// Power saving clock control: sleep/idle selection, CPU throttle,
// per-module power-off gating and system clock gating, Wishbone slave.
// Assumes CPU event inputs come from logic on the same clock.
//
// How it works
// - Sleep alone stops system and instruction clocks
// - Other enabled clock sources keep running in Sleep
// - Regulator bit 1 selects low-power Sleep
// - Regulator bit 0 reads one, upper bits zero
// - Idle-select bit picks Idle or full Sleep
// - Throttle-active bit applies ratio, else full speed
// - Wake-full-speed clears throttle on ISR entry
// - Throttle-on-return sets throttle on ISR return
// - Ratio field 000 is 1:2, doubling to 1:256
// - Debugger forces full speed, bit kept
// - Reset clears all module power-off bits
// - Powered-off module gets no clock, held reset
// - Powered-off module registers ignore writes, read zero
// - Powered-off module input selection is disabled
// - Re-enabled module restarts from its reset state
// - Gate bit stops system clock to peripherals
// - Any interrupt ends Idle, idle-select kept
// - Watchdog in Idle wakes, never resets
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module psc_power_ctrl #(
    parameter int MOD_SEL_W = 3,
    parameter int NCLK = 4
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [psc_pkg::ADR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire psc_pkg::psc_cpu_ev_t cpu_ev,
    input wire logic [NCLK-1:0] other_clk_req,
    output logic [NCLK-1:0] other_clk_en,
    output psc_pkg::psc_clk_out_t clk_out,
    output logic [(1<<MOD_SEL_W)-1:0] module_clk_en,
    output logic [(1<<MOD_SEL_W)-1:0] module_reset_hold,
    output logic [(1<<MOD_SEL_W)-1:0] module_insel_en,
    input wire logic [MOD_SEL_W-1:0] sfr_mod_sel,
    input wire logic sfr_wr_req,
    input wire logic [7:0] sfr_rd_data_in,
    output logic sfr_wr_allow,
    output logic [7:0] sfr_rd_data
);

    localparam int NMOD = 1 << MOD_SEL_W;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    psc_pkg::psc_state_t state_r, state_nxt;
    logic [7:0] regulator_r, regulator_nxt;
    logic [7:0] throttle_r, throttle_nxt;
    logic [NMOD-1:0] off_r, off_nxt;
    logic [NMOD-1:0] pend_r, pend_nxt;
    logic gate_r, gate_nxt;
    logic [1:0] div_r, div_nxt;
    logic [7:0] thr_cnt_r, thr_cnt_nxt;
    logic [3:0] thr_cfg_r, thr_cfg_nxt;
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    psc_pkg::psc_clk_out_t clk_r, clk_nxt;
    logic [NCLK-1:0] oclk_r, oclk_nxt;
    logic [NMOD-1:0] mclk_r, mclk_nxt;
    logic [NMOD-1:0] mrst_r, mrst_nxt;
    logic [NMOD-1:0] insel_r, insel_nxt;
    logic sfr_wr_r, sfr_wr_nxt;
    logic [7:0] sfr_rd_r, sfr_rd_nxt;

    logic wb_req;
    logic wr_en;
    logic instr_pulse;
    logic [7:0] thr_last;
    logic cpu_adv;
    logic [2:0] ratio;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        wb_req = wb_cyc & wb_stb & ~ack_r;
        wr_en = wb_req & wb_we & wb_sel[0];
        instr_pulse = (div_r == psc_pkg::INSTR_LAST);
        ratio = throttle_r[psc_pkg::RATIO_W-1:0];
        // Ratio 1:(2 << field); counter wraps at ratio minus one
        thr_last = 8'((psc_pkg::RATIO_BASE << ratio) - 9'h001);

        state_nxt = state_r;
        regulator_nxt = regulator_r;
        throttle_nxt = throttle_r;
        off_nxt = off_r;
        gate_nxt = gate_r;
        ack_nxt = wb_req;
        dat_nxt = dat_r;
        div_nxt = instr_pulse ? 2'h0 : div_r + 2'h1;

        // Register writes; only byte lane 0 carries data
        if (wr_en) begin
            case (wb_adr)
                psc_pkg::ADDR_REGULATOR: begin
                    regulator_nxt = (wb_dat_w[7:0] & psc_pkg::REGULATOR_WMASK)
                        | psc_pkg::REGULATOR_FIXED;
                end
                psc_pkg::ADDR_THROTTLE: begin
                    throttle_nxt = wb_dat_w[7:0] & psc_pkg::THROTTLE_WMASK;
                end
                psc_pkg::ADDR_MODULE_OFF: begin
                    off_nxt = wb_dat_w[NMOD-1:0];
                end
                psc_pkg::ADDR_SYSCLK_GATE: begin
                    gate_nxt = wb_dat_w[psc_pkg::GATE_BIT];
                end
                default: ;
            endcase
        end

        // Hardware clear first, hardware set last so a set wins
        if (cpu_ev.isr_entry && throttle_r[psc_pkg::WAKE_FULL_BIT]) begin
            throttle_nxt[psc_pkg::THROTTLE_BIT] = 1'b0;
        end
        if (cpu_ev.return_from_isr_instr
            && throttle_r[psc_pkg::THR_RETURN_BIT]) begin
            throttle_nxt[psc_pkg::THROTTLE_BIT] = 1'b1;
        end

        // Register reads
        dat_nxt = 32'h0000_0000;
        if (wb_req && !wb_we) begin
            case (wb_adr)
                psc_pkg::ADDR_REGULATOR: dat_nxt[7:0] = regulator_r;
                psc_pkg::ADDR_THROTTLE: dat_nxt[7:0] = throttle_r;
                psc_pkg::ADDR_MODULE_OFF: dat_nxt[NMOD-1:0] = off_r;
                psc_pkg::ADDR_SYSCLK_GATE: dat_nxt[psc_pkg::GATE_BIT] = gate_r;
                psc_pkg::ADDR_STATUS: dat_nxt[1:0] = state_r;
                default: dat_nxt = 32'h0000_0000;
            endcase
        end

        // Power state; idle-select is never touched here
        case (state_r)
            psc_pkg::PSC_RUN: begin
                // A pending interrupt turns the sleep instruction into a no-op
                if (cpu_ev.sleep_instr && !cpu_ev.irq_pending) begin
                    state_nxt = throttle_r[psc_pkg::IDLE_SEL_BIT]
                        ? psc_pkg::PSC_IDLE : psc_pkg::PSC_SLEEP;
                end
            end
            psc_pkg::PSC_IDLE: begin
                if (cpu_ev.irq_pending || cpu_ev.wdt_timeout) begin
                    state_nxt = psc_pkg::PSC_RUN;
                end
            end
            psc_pkg::PSC_SLEEP: begin
                if (cpu_ev.irq_pending) begin
                    state_nxt = psc_pkg::PSC_RUN;
                end
            end
            default: state_nxt = psc_pkg::PSC_RUN;
        endcase

        // Throttle counter in instruction cycles
        thr_cfg_nxt = {throttle_r[psc_pkg::THROTTLE_BIT], ratio};
        if (thr_cfg_nxt != thr_cfg_r) begin
            thr_cnt_nxt = 8'h00;
        end else if (instr_pulse) begin
            thr_cnt_nxt = (thr_cnt_r == thr_last) ? 8'h00 : thr_cnt_r + 8'h01;
        end else begin
            thr_cnt_nxt = thr_cnt_r;
        end
        // The debugger overrides speed without touching the stored bit
        cpu_adv = instr_pulse && (state_r == psc_pkg::PSC_RUN)
            && (!throttle_r[psc_pkg::THROTTLE_BIT]
                || cpu_ev.in_circuit_debugger
                || thr_cnt_r == thr_last);

        // Clock enables; the block itself always runs on its clock
        clk_nxt.sys_clk_en = (state_r != psc_pkg::PSC_SLEEP);
        clk_nxt.instr_clk_en = instr_pulse
            && (state_r != psc_pkg::PSC_SLEEP);
        clk_nxt.cpu_clk_en = cpu_adv;
        clk_nxt.periph_sysclk_en = (state_r != psc_pkg::PSC_SLEEP)
            && !gate_r;
        clk_nxt.sleep_regulator_low_power = (state_r == psc_pkg::PSC_SLEEP)
            && regulator_r[psc_pkg::REG_LOW_POWER_BIT];
        clk_nxt.wdt_reset = cpu_ev.wdt_timeout
            && (state_r != psc_pkg::PSC_IDLE);
        oclk_nxt = other_clk_req;

        // Module power-off; a re-enabled module stays in reset until the next
        // instruction clock pulse so it comes up clean with its clock running
        pend_nxt = (off_r & ~off_nxt) | (pend_r & ~off_nxt
            & {NMOD{~instr_pulse}});
        mclk_nxt = ~off_r;
        mrst_nxt = off_r | pend_r;
        insel_nxt = ~off_r;
        sfr_wr_nxt = sfr_wr_req && !off_r[sfr_mod_sel];
        sfr_rd_nxt = off_r[sfr_mod_sel] ? 8'h00 : sfr_rd_data_in;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_r <= psc_pkg::PSC_RUN;
            regulator_r <= psc_pkg::REGULATOR_RST;
            throttle_r <= psc_pkg::THROTTLE_RST;
            off_r <= NMOD'(psc_pkg::MODULE_OFF_RST);
            pend_r <= '0;
            gate_r <= 1'b0;
            div_r <= 2'h0;
            thr_cnt_r <= 8'h00;
            thr_cfg_r <= 4'h0;
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            clk_r <= '0;
            oclk_r <= '0;
            mclk_r <= '0;
            mrst_r <= '1;
            insel_r <= '0;
            sfr_wr_r <= 1'b0;
            sfr_rd_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            regulator_r <= regulator_nxt;
            throttle_r <= throttle_nxt;
            off_r <= off_nxt;
            pend_r <= pend_nxt;
            gate_r <= gate_nxt;
            div_r <= div_nxt;
            thr_cnt_r <= thr_cnt_nxt;
            thr_cfg_r <= thr_cfg_nxt;
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            clk_r <= clk_nxt;
            oclk_r <= oclk_nxt;
            mclk_r <= mclk_nxt;
            mrst_r <= mrst_nxt;
            insel_r <= insel_nxt;
            sfr_wr_r <= sfr_wr_nxt;
            sfr_rd_r <= sfr_rd_nxt;
        end
    end

    assign wb_ack = ack_r;
    assign wb_dat_r = dat_r;
    assign clk_out = clk_r;
    assign other_clk_en = oclk_r;
    assign module_clk_en = mclk_r;
    assign module_reset_hold = mrst_r;
    assign module_insel_en = insel_r;
    assign sfr_wr_allow = sfr_wr_r;
    assign sfr_rd_data = sfr_rd_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    chk_sleep_clocks: assert property (
        state_r == psc_pkg::PSC_SLEEP
        |=> !clk_r.sys_clk_en && !clk_r.instr_clk_en)
        else $error("clocks running in sleep");
    chk_idle_clocks: assert property (
        state_r == psc_pkg::PSC_IDLE |=> clk_r.sys_clk_en && !clk_r.cpu_clk_en)
        else $error("idle clock state wrong");
    chk_other_clock: assert property (
        state_r == psc_pkg::PSC_SLEEP && other_clk_req[0] |=> other_clk_en[0])
        else $error("other clock stopped in sleep");
    chk_low_power: assert property (
        state_r == psc_pkg::PSC_SLEEP && regulator_r[psc_pkg::REG_LOW_POWER_BIT]
        |=> clk_r.sleep_regulator_low_power)
        else $error("low power sleep not selected");
    chk_reserved_read: assert property (
        wb_req && !wb_we && wb_adr == psc_pkg::ADDR_REGULATOR
        |=> wb_ack && wb_dat_r[0] && wb_dat_r[31:2] == 30'h0)
        else $error("regulator read value wrong");
    chk_sleep_entry: assert property (
        state_r == psc_pkg::PSC_RUN && cpu_ev.sleep_instr && !cpu_ev.irq_pending
        |=> state_r == (throttle_r[psc_pkg::IDLE_SEL_BIT]
            ? psc_pkg::PSC_IDLE : psc_pkg::PSC_SLEEP))
        else $error("wrong power state after sleep");
    chk_full_speed: assert property (
        state_r == psc_pkg::PSC_RUN && !throttle_r[psc_pkg::THROTTLE_BIT]
        && instr_pulse |=> clk_r.cpu_clk_en)
        else $error("cpu cycle lost at full speed");
    chk_wake_clear: assert property (
        cpu_ev.isr_entry && throttle_r[psc_pkg::WAKE_FULL_BIT]
        && !cpu_ev.return_from_isr_instr && !wr_en
        |=> !throttle_r[psc_pkg::THROTTLE_BIT])
        else $error("throttle not cleared on isr entry");
    chk_return_set: assert property (
        cpu_ev.return_from_isr_instr && throttle_r[psc_pkg::THR_RETURN_BIT]
        |=> throttle_r[psc_pkg::THROTTLE_BIT])
        else $error("throttle not set on return");
    chk_debug_speed: assert property (
        state_r == psc_pkg::PSC_RUN && cpu_ev.in_circuit_debugger
        && instr_pulse && !wr_en && !cpu_ev.isr_entry
        && !cpu_ev.return_from_isr_instr
        |=> clk_r.cpu_clk_en && $stable(throttle_r))
        else $error("debugger not at full speed");
    chk_module_off: assert property (
        off_r[0] |=> module_reset_hold[0] && !module_clk_en[0]
            && !module_insel_en[0])
        else $error("powered-off module still active");
    chk_sfr_mask: assert property (
        off_r[sfr_mod_sel] |=> sfr_rd_data == 8'h00 && !sfr_wr_allow)
        else $error("powered-off module registers reachable");
    chk_reenable: assert property (
        $fell(off_r[0]) |=> module_reset_hold[0] ##[1:8] !module_reset_hold[0])
        else $error("module reset release wrong");
    chk_idle_exit: assert property (
        state_r == psc_pkg::PSC_IDLE && cpu_ev.irq_pending && !wr_en
        |=> state_r == psc_pkg::PSC_RUN
            && $stable(throttle_r[psc_pkg::IDLE_SEL_BIT]))
        else $error("idle exit wrong");
    chk_wdt_idle: assert property (
        state_r == psc_pkg::PSC_IDLE && cpu_ev.wdt_timeout
        |=> !clk_r.wdt_reset && state_r == psc_pkg::PSC_RUN)
        else $error("watchdog reset in idle");

    cov_idle_cycle: cover property (
        state_r == psc_pkg::PSC_IDLE ##1 state_r == psc_pkg::PSC_RUN);
    cov_sleep_entry: cover property (state_r == psc_pkg::PSC_SLEEP);
    cov_throttled: cover property (
        throttle_r[psc_pkg::THROTTLE_BIT] && clk_r.cpu_clk_en);
    cov_reenable: cover property ($fell(off_r[0]));

endmodule

// *** tb/test_power_saving_clock_control.sv ***
// Self-checking testbench for the power saving clock control block.
// Assumes psc_pkg is compiled first; the bench drives every design port.
`timescale 1ns/1ps
module test_power_saving_clock_control;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic wb_cyc, wb_stb, wb_we, wb_ack, sfr_wr_req, sfr_wr_allow;
    logic [7:0] wb_adr, sfr_rd_data_in, sfr_rd_data;
    logic [7:0] mod_clk, mod_hold, mod_insel;
    logic [3:0] wb_sel, other_req, other_en;
    logic [31:0] wb_dat_w, wb_dat_r;
    logic [2:0] sfr_mod_sel;
    psc_pkg::psc_cpu_ev_t cpu_ev;
    psc_pkg::psc_clk_out_t co;
    int fail_count = 0;
    int comparisons = 0;

    always #20 clock = ~clock;

    psc_power_ctrl #(.MOD_SEL_W(3), .NCLK(4)) dut_u (
        .clock(clock), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .cpu_ev(cpu_ev), .other_clk_req(other_req), .other_clk_en(other_en),
        .clk_out(co), .module_clk_en(mod_clk), .module_reset_hold(mod_hold),
        .module_insel_en(mod_insel), .sfr_mod_sel(sfr_mod_sel),
        .sfr_wr_req(sfr_wr_req), .sfr_rd_data_in(sfr_rd_data_in),
        .sfr_wr_allow(sfr_wr_allow), .sfr_rd_data(sfr_rd_data)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    // Reads compare the whole returned word with d zero-extended; outputs are sampled at the
    // edge, so the value seen is the one that stood during that cycle
    task automatic xfer(input logic we, input logic [7:0] adr,
                        input logic [7:0] d, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clock);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= {24'h000000, d};
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack !== 1'h1 && n < 50);
        check({31'h0, wb_ack}, 32'h1, "bus answer");
        if (!we) check(wb_dat_r, {24'h000000, d}, "read data");
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        xfer(1'h1, adr, d, 4'h1);
    endtask

    task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
        xfer(1'h0, adr, exp, 4'h1);
    endtask

    function automatic psc_pkg::psc_cpu_ev_t ev(input int k);
        psc_pkg::psc_cpu_ev_t e;
        e = '0;
        e[k] = 1'h1;
        return e;
    endfunction

    // Event bits: 5 sleep, 4 isr entry, 3 return, 2 debugger, 1 irq, 0 wdt
    task automatic pulse(input int k);
        @(posedge clock);
        cpu_ev <= ev(k);
        @(posedge clock);
        cpu_ev <= '0;
    endtask

    task automatic count(input int len, output int ci, output int cc);
        ci = 0;
        cc = 0;
        repeat (len) begin
            @(posedge clock);
            ci += int'(co.instr_clk_en === 1'h1);
            cc += int'(co.cpu_clk_en === 1'h1);
        end
    endtask

    task automatic sfr(input logic [2:0] sel, input logic [8:0] exp);
        @(posedge clock);
        sfr_mod_sel <= sel;
        sfr_wr_req <= 1'h1;
        sfr_rd_data_in <= 8'hA5;
        @(posedge clock);
        sfr_wr_req <= 1'h0;
        @(posedge clock);
        check({sfr_wr_allow, sfr_rd_data}, exp, "sfr gate");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(8'h00, 8'h01);
        wr(8'h00, 8'hFE);
        rd(8'h00, 8'h03);
        xfer(1'h1, 8'h00, 8'h00, 4'h0);
        rd(8'h00, 8'h03);
        wr(8'h00, 8'h00);
        rd(8'h00, 8'h01);
        rd(8'h04, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h0C, 8'h00);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        wr(8'h14, 8'hFF);
        rd(8'h14, 8'h00);
        $display("register test done");
    endtask

    task automatic t_sleep();
        int lp;
        @(posedge clock);
        other_req <= 4'hB;
        // A sleep with an interrupt already pending must not sleep at all
        cpu_ev <= ev(5) | ev(1);
        @(posedge clock);
        cpu_ev <= '0;
        rd(8'h10, 8'h00);
        check(co.sys_clk_en, 32'h1, "sleep refused");
        for (lp = 0; lp < 2; lp++) begin
            wr(8'h00, {6'h00, 1'(lp), 1'h1});
            pulse(5);
            repeat (4) @(posedge clock);
            repeat (8) begin
                @(posedge clock);
                check({co.sys_clk_en, co.instr_clk_en, co.periph_sysclk_en},
                      32'h0, "sleep clocks");
                check(co.sleep_regulator_low_power, lp, "regulator");
                check(other_en, 32'hB, "other clocks");
            end
            pulse(1);
            repeat (4) @(posedge clock);
            check(co.sys_clk_en, 32'h1, "woken clock");
            rd(8'h10, 8'h00);
        end
        wr(8'h00, 8'h01);
        $display("sleep test done");
    endtask

    task automatic t_idle();
        logic seen;
        seen = 1'h0;
        pulse(0);
        repeat (3) begin
            @(posedge clock);
            seen = seen | (co.wdt_reset === 1'h1);
        end
        check(seen, 32'h1, "wdt reset in run");
        wr(8'h04, 8'hE0);
        pulse(5);
        repeat (4) @(posedge clock);
        repeat (16) begin
            @(posedge clock);
            check({co.sys_clk_en, co.periph_sysclk_en, co.cpu_clk_en},
                  32'h6, "idle clocks");
        end
        pulse(0);
        repeat (3) begin
            @(posedge clock);
            check(co.wdt_reset, 32'h0, "wdt reset in idle");
        end
        rd(8'h10, 8'h00);
        rd(8'h04, 8'hE0);
        pulse(5);
        repeat (4) @(posedge clock);
        rd(8'h10, 8'h01);
        pulse(1);
        repeat (2) @(posedge clock);
        rd(8'h10, 8'h00);
        rd(8'h04, 8'hE0);
        wr(8'h04, 8'h00);
        $display("idle test done");
    endtask

    task automatic t_throttle();
        int n, ci, cc;
        count(64, ci, cc);
        check(ci, 32'd16, "instr rate");
        check(cc, ci, "full speed");
        for (n = 0; n < 8; n++) begin
            // A window of four CPU steps; restart phase allows one either way
            wr(8'h04, 8'h40 | 8'(n));
            count(16 * (2 << n), ci, cc);
            check(cc >= 3 && cc <= 5, 32'h1, "throttle ratio");
        end
        @(posedge clock);
        cpu_ev <= ev(2);
        // Let the design see the debugger level before counting starts
        @(posedge clock);
        count(64, ci, cc);
        check(cc, ci, "debugger speed");
        cpu_ev <= '0;
        rd(8'h04, 8'h47);
        wr(8'h04, 8'h00);
        $display("throttle test done");
    endtask

    task automatic t_isr();
        wr(8'h04, 8'h60);
        pulse(4);
        rd(8'h04, 8'h20);
        wr(8'h04, 8'h10);
        pulse(3);
        rd(8'h04, 8'h50);
        wr(8'h04, 8'h40);
        pulse(4);
        rd(8'h04, 8'h40);
        wr(8'h04, 8'h00);
        pulse(3);
        rd(8'h04, 8'h00);
        $display("interrupt test done");
    endtask

    task automatic t_modules();
        wr(8'h08, 8'h81);
        @(posedge clock);
        check({mod_clk, mod_hold, mod_insel}, 32'h7E817E,
              "module off");
        sfr(3'h0, 9'h000);
        sfr(3'h7, 9'h000);
        sfr(3'h1, 9'h1A5);
        wr(8'h08, 8'h00);
        // Software holds off for more than one instruction
        repeat (8) @(posedge clock);
        check({mod_clk, mod_hold, mod_insel}, 32'hFF00FF, "module on");
        sfr(3'h0, 9'h1A5);
        wr(8'h0C, 8'h01);
        @(posedge clock);
        check({co.sys_clk_en, co.periph_sysclk_en}, 32'h2, "gate on");
        rd(8'h0C, 8'h01);
        wr(8'h0C, 8'h00);
        @(posedge clock);
        check({co.sys_clk_en, co.periph_sysclk_en}, 32'h3, "gate off");
        $display("module test done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        wb_cyc = 1'h0;
        wb_stb = 1'h0;
        wb_we = 1'h0;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_w = 32'h0;
        cpu_ev = '0;
        other_req = 4'h0;
        sfr_mod_sel = 3'h0;
        sfr_wr_req = 1'h0;
        sfr_rd_data_in = 8'h00;
        repeat (10) @(posedge clock);
        reset <= 1'h0;
        t_regs();
        t_sleep();
        t_idle();
        t_throttle();
        t_isr();
        t_modules();
        test_done();
    end

    // Whole run is near 9k cycles; 50k cycles means a hang
    initial begin
        #2000000;
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        test_done();
    end
endmodule
